// ---- lvds_adc_capture.sv ----
// Contract
// - Bit-wise DDR: odd bits on rising edge, even on falling, merged per period.
// - Bit-wise DDR uses half as many data lanes as sample bits.
// - Sample-wise DDR: one lane per bit, a full sample every edge.
// - One-wire serial: one lane per channel, 12, 14 or 16 bits per word.
// - Serial bits are taken on both edges of the bit clock.
// - Frame clock rising edge marks the start of each serial word.
// - All lanes share one bit clock and one frame clock.
// - Two-wire serial: two lanes per channel, recombined into one sample.
// - Parallel or serial family is fixed by the loaded strap, never both.
// - Samples go out as a parallel word with a sample clock on headers.
// - Header outputs start disabled in the parallel family.
// - The same sample word feeds the capture memory.
// - Capture memory holds up to 65536 consecutive samples.
// - Link writes set record length and channel; logic obeys them.
// - A UART carries register writes in and captured samples out.
// - Converter side has 14 data lanes plus bit and frame clocks.
// - Clear request empties capture storage, keeps every register.
`timescale 1ns/100ps
`include "adc_capture_consts.svh"

// ------------------------------------------------------------
// Small FIFO between memory reader and UART transmitter
// ------------------------------------------------------------
module sync_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign out_valid = (wp != rp);
  assign out_data  = mem[rp[AW-1:0]];

  // Pointer update; clear drops any queued words
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
    end
    else if (clr)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wp <= wp + 1'b1;
      if (out_valid && out_ready)
        rp <= rp + 1'b1;
    end
  end

  // Storage, written only when accepted
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[wp[AW-1:0]] <= in_data;
  end
endmodule

// ------------------------------------------------------------
// Converter capture top
// ------------------------------------------------------------
module lvds_adc_capture #(
  parameter int LANES = 14,
  parameter int DEPTH = 65536
) (
  input  wire logic               CORE_CLK,
  input  wire logic               RST,
  input  wire logic [LANES-1:0]   LANE,
  input  wire logic               BIT_CLK,
  input  wire logic               FRAME_CLK,
  input  wire logic               CFG_SERIAL,
  input  wire logic               CFG_FMT,
  input  wire logic [1:0]         CFG_RES,
  input  wire logic               CLR_REQ,
  input  wire logic               UART_RX,
  output logic                    UART_TX,
  output logic [15:0]             HDR_DATA,
  output logic                    HDR_CLK,
  output logic                    HDR_OE,
  output adc_capture_pkg::cap_t   CAP_STATE
);
  import adc_capture_pkg::*;

  localparam int SW = 16;
  localparam int HL = SW / 2;
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] LEN_MAX = 16'(DEPTH - 1);
  localparam logic [3:0]  CH_MAX  = 4'(LANES - 1);

  initial if (LANES < HL || LANES > SW) $error("lane count out of range");
  initial if (DEPTH < 2 || DEPTH > 65536 || (1 << AW) != DEPTH) $error("bad depth");

  typedef struct packed {
    logic [LANES-1:0]         ln_m, ln_s;
    logic                     bc_m, bc_s, bc_p, fc_m, fc_s, fc_p;
    logic                     rx_m, rx_s, cl_m, cl_s, cl_p;
    logic [3:0]               cf_m, cf_s;
    logic [1:0]               strap;
    logic                     serial, fmt;
    logic [1:0]               res;
    logic [HL-1:0]            half;
    logic [LANES-1:0][SW-1:0] sh;
    logic                     fseen;
    logic [4:0]               bcnt;
    logic [SW-1:0]            smp;
    logic                     vld;
    logic [SW-1:0]            hdata;
    logic                     hclk, hoe, hen;
    logic [15:0]              rec_len;
    logic [3:0]               chan;
    logic [15:0]              baud;
    cap_t                     cap;
    logic [AW:0]              wptr, rptr;
    logic                     pend;
    logic                     rx_busy;
    logic [15:0]              rx_cnt;
    logic [3:0]               rx_bit;
    logic [7:0]               rx_sh;
    logic [1:0]               p_idx;
    logic [6:0]               p_addr;
    logic [7:0]               p_hi;
    logic                     tx_busy;
    logic [15:0]              tx_cnt;
    logic [3:0]               tx_bit;
    logic [9:0]               tx_sh;
    logic                     lo_pend;
    logic [7:0]               lo_byte;
    logic                     txd;
  } st_t;

  function automatic st_t rst_val();
    st_t v;
    v         = '0;
    v.rx_m    = 1'b1;
    v.rx_s    = 1'b1;
    v.txd     = 1'b1;
    v.baud    = `BAUD_RST;
    v.chan    = `CHAN_RST;
    v.rec_len = (`REC_LEN_RST > LEN_MAX) ? LEN_MAX : `REC_LEN_RST;
    v.cap     = CAP_IDLE;
    return v;
  endfunction
  localparam st_t ST_RST = rst_val();

  // Odd bits from the rising half, even bits from the falling half
  function automatic logic [SW-1:0] merge(input logic [HL-1:0] odd, input logic [HL-1:0] even);
    logic [SW-1:0] w;
    w = '0;
    for (int i = 0; i < HL; i++)
    begin
      w[2*i+1] = odd[i];
      w[2*i]   = even[i];
    end
    return w;
  endfunction

  function automatic logic [4:0] res_bits(input logic [1:0] code);
    return (code == 2'h0) ? 5'd12 : (code == 2'h1) ? 5'd14 : 5'd16;
  endfunction

  st_t           r;
  st_t           n;
  logic [SW-1:0] cap_mem [DEPTH];
  logic [SW-1:0] mem_q;
  logic          mem_we;
  logic          fin_vld, fin_rdy, fout_vld, fout_rdy, fifo_clr;
  logic [SW-1:0] fout_data;
  logic          rx_ok, arm_req, upld_req;
  logic          bc_rise, bc_fall, bc_edge, fc_rise, cl_rise, done;
  logic [4:0]    nbits;
  logic [SW-1:0] rmask;
  logic [3:0]    ch_a, ch_b;
  logic [15:0]   wd;

  // Edge finders look only at second-stage samples
  assign bc_rise = r.bc_s & ~r.bc_p;
  assign bc_fall = ~r.bc_s & r.bc_p;
  assign bc_edge = bc_rise | bc_fall;
  assign fc_rise = r.fc_s & ~r.fc_p;
  assign cl_rise = r.cl_s & ~r.cl_p;
  assign done    = (r.strap == `STRAP_DONE);
  assign nbits   = r.fmt ? (res_bits(r.res) >> 1) : res_bits(r.res);
  assign rmask   = SW'((17'h1_0000 >> (5'd16 - res_bits(r.res))) - 17'h0_0001);
  assign wd      = {r.p_hi, r.rx_sh};
  // Two-wire pairs lanes 2c and 2c+1 using c mod 8; pairs beyond the last full lane pair fall back to lane 0
  assign ch_a    = !r.fmt ? r.chan : ({r.chan[2:0], 1'b0} > CH_MAX - 4'h1) ? 4'h0
                   : {r.chan[2:0], 1'b0};
  assign ch_b    = r.fmt ? ch_a + 4'h1 : ch_a;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    n        = r;
    mem_we   = 1'b0;
    fin_vld  = 1'b0;
    fout_rdy = 1'b0;
    fifo_clr = 1'b0;
    rx_ok    = 1'b0;
    arm_req  = 1'b0;
    upld_req = 1'b0;
    n.vld    = 1'b0;

    // Two-stage sampling of every pin; clocks are just inputs here
    n.ln_m = LANE;
    n.ln_s = r.ln_m;
    n.bc_m = BIT_CLK;
    n.bc_s = r.bc_m;
    n.bc_p = r.bc_s;
    n.fc_m = FRAME_CLK;
    n.fc_s = r.fc_m;
    n.fc_p = r.fc_s;
    n.rx_m = UART_RX;
    n.rx_s = r.rx_m;
    n.cl_m = CLR_REQ;
    n.cl_s = r.cl_m;
    n.cl_p = r.cl_s;
    n.cf_m = {CFG_RES, CFG_FMT, CFG_SERIAL};
    n.cf_s = r.cf_m;

    // Straps caught once after release; family is frozen from then on
    if (!done)
    begin
      n.strap = r.strap + 2'h1;
      if (r.strap == `STRAP_LATCH)
      begin
        n.serial = r.cf_s[0];
        n.fmt    = r.cf_s[1];
        n.res    = r.cf_s[3:2];
        n.hen    = r.cf_s[0];
      end
    end

    // Frame edge seen between bit edges restarts the word count
    if (fc_rise)
      n.fseen = 1'b1;

    if (done && bc_edge)
    begin
      if (!r.serial)
      begin
        if (!r.fmt)
        begin
          if (bc_rise)
            n.half = r.ln_s[HL-1:0];
          else
          begin
            n.smp = merge(r.half, r.ln_s[HL-1:0]);
            n.vld = 1'b1;
          end
        end
        else
        begin
          n.smp = SW'(r.ln_s);
          n.vld = 1'b1;
        end
      end
      else
      begin
        // Every lane shifts on the same shared edge
        for (int i = 0; i < LANES; i++)
          n.sh[i] = {r.sh[i][SW-2:0], r.ln_s[i]};
        n.bcnt  = (r.fseen || fc_rise) ? 5'd1 : r.bcnt + 5'd1;
        n.fseen = 1'b0;
        if (n.bcnt == nbits)
        begin
          if (r.fmt)
            n.smp = merge(n.sh[ch_a][HL-1:0], n.sh[ch_b][HL-1:0]) & rmask;
          else
            n.smp = n.sh[ch_a] & rmask;
          n.vld = 1'b1;
        end
      end
    end

    // Header word changes with a toggling sample clock
    if (r.vld)
    begin
      n.hdata = r.smp;
      n.hclk  = ~r.hclk;
    end
    n.hoe = r.hen;

    // UART receiver, 8N1, middle-of-bit sampling
    if (!r.rx_busy)
    begin
      if (!r.rx_s)
      begin
        n.rx_busy = 1'b1;
        n.rx_cnt  = r.baud >> 1;
        n.rx_bit  = 4'h0;
      end
    end
    else if (r.rx_cnt != 16'h0000)
      n.rx_cnt = r.rx_cnt - 16'h0001;
    else
    begin
      n.rx_cnt = r.baud;
      n.rx_bit = r.rx_bit + 4'h1;
      if (r.rx_bit == 4'h0 && r.rx_s)
        n.rx_busy = 1'b0;       // Glitch, not a start bit
      else if (r.rx_bit == `UART_STOP_BIT)
      begin
        n.rx_busy = 1'b0;
        rx_ok     = r.rx_s;
      end
      else if (r.rx_bit != 4'h0)
        n.rx_sh = {r.rx_s, r.rx_sh[7:1]};
    end

    // Three-byte writes: flagged address, data high, data low
    if (rx_ok)
    begin
      case (r.p_idx)
        2'h0:
        begin
          if (r.rx_sh[`CMD_FLAG_BIT])
          begin
            n.p_addr = r.rx_sh[6:0];
            n.p_idx  = 2'h1;
          end
        end
        2'h1:
        begin
          n.p_hi  = r.rx_sh;
          n.p_idx = 2'h2;
        end
        default:
        begin
          n.p_idx = 2'h0;
          case (r.p_addr)
            `REG_REC_LEN: n.rec_len = (wd > LEN_MAX) ? LEN_MAX : wd;
            `REG_CHAN:    n.chan = (wd > 16'(CH_MAX)) ? CH_MAX : wd[3:0];
            `REG_BAUD:    n.baud = (wd < `BAUD_MIN) ? `BAUD_MIN : wd;
            `REG_HDR_EN:  n.hen = wd[`HDR_EN_BIT];
            `REG_CTRL:
            begin
              arm_req  = wd[`CTRL_ARM_BIT];
              upld_req = wd[`CTRL_UPLD_BIT];
            end
            default:      n.p_idx = 2'h0;   // Unknown address dropped
          endcase
        end
      endcase
    end

    // Capture sequencer
    unique case (r.cap)
      CAP_IDLE, CAP_FULL:
      begin
        if (arm_req)
        begin
          n.cap  = CAP_RUN;
          n.wptr = '0;
        end
        else if (upld_req && r.cap == CAP_FULL)
        begin
          n.cap  = CAP_UPLD;
          n.rptr = '0;
          n.pend = 1'b0;
        end
      end
      CAP_RUN:
      begin
        if (r.vld)
        begin
          mem_we = 1'b1;
          n.wptr = r.wptr + 1'b1;
          if (r.wptr == {1'b0, r.rec_len[AW-1:0]})
            n.cap = CAP_FULL;
        end
      end
      CAP_UPLD:
      begin
        // Read takes a cycle; the word waits in mem_q until the FIFO takes it
        fin_vld = r.pend;
        if (!r.pend)
          n.pend = 1'b1;
        else if (fin_rdy)
        begin
          n.pend = 1'b0;
          n.rptr = r.rptr + 1'b1;
          if (r.rptr == {1'b0, r.rec_len[AW-1:0]})
            n.cap = CAP_FULL;   // Data kept for another upload
        end
      end
    endcase

    // Clear empties storage but leaves settings alone
    if (cl_rise)
    begin
      n.cap    = CAP_IDLE;
      n.wptr   = '0;
      n.rptr   = '0;
      n.pend   = 1'b0;
      fifo_clr = 1'b1;
    end

    // UART transmitter, high byte first
    if (!r.tx_busy)
    begin
      if (r.lo_pend)
      begin
        n.lo_pend = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_sh   = {1'b1, r.lo_byte, 1'b0};
        n.tx_cnt  = 16'h0000;
        n.tx_bit  = 4'h0;
      end
      else if (fout_vld)
      begin
        fout_rdy  = 1'b1;
        n.lo_pend = 1'b1;
        n.lo_byte = fout_data[7:0];
        n.tx_busy = 1'b1;
        n.tx_sh   = {1'b1, fout_data[15:8], 1'b0};
        n.tx_cnt  = 16'h0000;
        n.tx_bit  = 4'h0;
      end
    end
    else if (r.tx_cnt != 16'h0000)
      n.tx_cnt = r.tx_cnt - 16'h0001;
    else if (r.tx_bit == `UART_FRAME)
      n.tx_busy = 1'b0;
    else
    begin
      n.txd    = r.tx_sh[0];
      n.tx_sh  = {1'b1, r.tx_sh[9:1]};
      n.tx_cnt = r.baud;
      n.tx_bit = r.tx_bit + 4'h1;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      r <= ST_RST;
    else
      r <= n;
  end

  // Capture memory; no reset, contents are only valid up to the write pointer
  always_ff @(posedge CORE_CLK)
  begin
    if (mem_we)
      cap_mem[r.wptr[AW-1:0]] <= r.smp;
    mem_q <= cap_mem[r.rptr[AW-1:0]];
  end

  // Slow UART drains this; a full FIFO stalls the memory reader
  sync_fifo #(
    .W     (SW),
    .DEPTH (8)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .clr       (fifo_clr),
    .in_valid  (fin_vld),
    .in_ready  (fin_rdy),
    .in_data   (mem_q),
    .out_valid (fout_vld),
    .out_ready (fout_rdy),
    .out_data  (fout_data)
  );

  assign UART_TX   = r.txd;
  assign HDR_DATA  = r.hdata;
  assign HDR_CLK   = r.hclk;
  assign HDR_OE    = r.hoe;
  assign CAP_STATE = r.cap;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  ddr_bit_merge_a: assert property (done && !r.serial && !r.fmt && bc_fall |=>
    r.vld && r.smp[0] == $past(r.ln_s[0]) && r.smp[1] == $past(r.half[0]))
    else $error("bit-wise merge wrong");
  half_lane_top_a: assert property (done && !r.serial && !r.fmt && bc_fall |=>
    r.smp[15] == $past(r.half[7]) && r.smp[14] == $past(r.ln_s[7]))
    else $error("upper bit-wise lane wrong");
  sample_edge_a: assert property (done && !r.serial && r.fmt && bc_edge |=>
    r.vld && r.smp == SW'($past(r.ln_s)))
    else $error("sample-wise word not taken");
  serial_edge_a: assert property (r.vld && r.serial |-> $past(bc_edge))
    else $error("serial word off a bit edge");
  frame_start_a: assert property (done && r.serial && bc_edge && fc_rise |=>
    r.bcnt == 5'd1)
    else $error("frame edge did not restart count");
  word_width_a: assert property (r.vld && r.serial |-> (r.smp & ~rmask) == '0
    && r.bcnt == nbits)
    else $error("serial word length wrong");
  header_follow_a: assert property (r.vld |=> r.hdata == $past(r.smp)
    && r.hclk != $past(r.hclk))
    else $error("header did not follow sample");
  mem_same_word_a: assert property (mem_we |=>
    r.hdata == cap_mem[$past(r.wptr[AW-1:0])])
    else $error("stored word differs from header word");
  header_default_a: assert property (r.strap == `STRAP_LATCH |-> ##2
    r.hoe == $past(r.cf_s[0], 2))
    else $error("header enable default wrong");
  family_frozen_a: assert property (done |=> $stable(r.serial) && $stable(r.fmt))
    else $error("family changed after load");
  len_clamp_a: assert property (r.rec_len <= LEN_MAX)
    else $error("record length above capacity");
  run_stop_a: assert property (r.cap == CAP_RUN && r.vld &&
    r.wptr == {1'b0, r.rec_len[AW-1:0]} && !cl_rise |=> r.cap == CAP_FULL)
    else $error("capture did not stop at length");
  clear_keep_a: assert property (cl_rise |=> r.cap == CAP_IDLE && r.wptr == '0
    && $stable(r.baud) && $stable(r.rec_len))
    else $error("clear misbehaved");
  rx_write_a: assert property (rx_ok && r.p_idx == 2'h2 && r.p_addr == `REG_CHAN
    |=> ($past(wd) > 16'(CH_MAX)) ? (r.chan == CH_MAX) : (r.chan == $past(wd[3:0])))
    else $error("channel write not applied");

  capture_done_c: cover property (r.cap == CAP_RUN ##1 r.cap == CAP_FULL);
  upload_end_c:   cover property (r.cap == CAP_UPLD ##1 r.cap == CAP_FULL);
  fifo_stall_c:   cover property (fin_vld && !fin_rdy);
  serial_word_c:  cover property (r.vld && r.serial && r.fmt);
endmodule

// ---- adc_capture_consts.svh ----
`ifndef ADC_CAPTURE_CONSTS_SVH
`define ADC_CAPTURE_CONSTS_SVH

// ------------------------------------------------------------
// Link register addresses (seven-bit, first byte of a write)
// ------------------------------------------------------------
`define REG_REC_LEN   7'h00
`define REG_CHAN      7'h01
`define REG_BAUD      7'h02
`define REG_HDR_EN    7'h03
`define REG_CTRL      7'h04

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CMD_FLAG_BIT  7
`define CTRL_ARM_BIT  0
`define CTRL_UPLD_BIT 1
`define HDR_EN_BIT    0

// ------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------
`define BAUD_RST      16'h0363
`define BAUD_MIN      16'h0004
`define REC_LEN_RST   16'hFFFF
`define CHAN_RST      4'h0
`define STRAP_LATCH   2'h2
`define STRAP_DONE    2'h3
`define UART_STOP_BIT 4'h9
`define UART_FRAME    4'hA

`endif

// ---- adc_capture_pkg.sv ----
// ------------------------------------------------------------
// Shared types
// ------------------------------------------------------------
package adc_capture_pkg;

  // Capture sequencer states
  typedef enum logic [1:0] {CAP_IDLE, CAP_RUN, CAP_FULL, CAP_UPLD} cap_t;

endpackage

// ---- adc_model.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// Converter side: lanes, bit clock, frame clock
// ------------------------------------------------------------
module adc_model (
  output logic [13:0] lane,
  output logic        bit_clk,
  output logic        frame_clk
);
  // Channel the host selected; two-wire uses lanes 2ch and 2ch+1
  int ch;

  // Clocks stand still between frames
  initial
  begin
    ch = 0;
    lane = 14'h0000;
    bit_clk = 1'b0;
    frame_clk = 1'b0;
  end

  // Lanes settle half a level before each edge; one clock pair for all lanes
  task automatic put(input logic [13:0] v, input logic f);
    lane = v;
    #20;
    bit_clk = ~bit_clk;
    frame_clk = f;
    #20;
  endtask

  // One sample word in the chosen format, 80 ns bit clock period
  task automatic send(input logic ser, input logic fmt, input int res, input logic [15:0] w);
    logic [13:0] v;
    int          k;
    int          n;
    v = 14'h0000;
    if (!ser && !fmt)
    begin
      for (k = 0; k < 8; k++)
        v[k] = w[2*k+1];
      put(v, 1'b0);
      for (k = 0; k < 8; k++)
        v[k] = w[2*k];
      put(v, 1'b0);
    end
    else if (!ser)
      put(w[13:0], 1'b0);
    else
    begin
      n = fmt ? res / 2 : res;
      for (k = 0; k < n; k++)
      begin
        // Unused lanes toggle so no stale level looks valid
        v = ~lane;
        if (fmt)
        begin
          v[2*ch] = w[res-1-2*k];
          v[2*ch+1] = w[res-2-2*k];
        end
        else
          v[ch] = w[res-1-k];
        put(v, k < n / 2);
      end
      frame_clk = 1'b0;
    end
    lane = ~lane; // Released lanes hide the last value
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "adc_capture_consts.svh"
module testbench;
  import adc_capture_pkg::*;
  localparam int DEPTH = 128;
  logic        clk;
  logic        rst;
  logic [13:0] lane;
  logic        bit_clk;
  logic        frame_clk;
  logic        cfg_serial;
  logic        cfg_fmt;
  logic [1:0]  cfg_res;
  logic        clr_req;
  logic        uart_rx;
  logic        uart_tx;
  logic [15:0] hdr_data;
  logic        hdr_clk;
  logic        hdr_oe;
  cap_t        cap_state;
  int          n_mismatch;
  int          checks;
  int          bt;
  logic [15:0] sent[$];
  logic [3:0]  modes[7] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hA, 4'hE, 4'hF};

  adc_model adc (.lane(lane), .bit_clk(bit_clk), .frame_clk(frame_clk));

  lvds_adc_capture #(.DEPTH(DEPTH)) dut (
    .CORE_CLK(clk), .RST(rst), .LANE(lane), .BIT_CLK(bit_clk), .FRAME_CLK(frame_clk),
    .CFG_SERIAL(cfg_serial), .CFG_FMT(cfg_fmt), .CFG_RES(cfg_res), .CLR_REQ(clr_req),
    .UART_RX(uart_rx), .UART_TX(uart_tx), .HDR_DATA(hdr_data), .HDR_CLK(hdr_clk),
    .HDR_OE(hdr_oe), .CAP_STATE(cap_state)
  );

  // ------------------------------------------------------------
  // Clock, helpers and checks
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_st(input cap_t got, input cap_t exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Header word expected for a format, masked to the serial resolution
  function automatic logic [15:0] exp_word(input logic ser, input logic fmt, input int res,
                                           input logic [15:0] w);
    logic [16:0] m;
    m = (17'h0_0001 << res) - 17'h0_0001;
    if (!ser)
      return fmt ? {2'b00, w[13:0]} : w;
    return w & m[15:0];
  endfunction

  // One 8N1 byte into the link, LSB first
  task automatic ux(input logic [7:0] b);
    int i;
    uart_rx = 1'b0;
    tick(bt);
    for (i = 0; i < 8; i++)
    begin
      uart_rx = b[i];
      tick(bt);
    end
    uart_rx = 1'b1;
    tick(bt);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    ux({1'b1, a});
    ux(d[15:8]);
    ux(d[7:0]);
    tick(4);
  endtask

  // One uploaded word: high byte, then low byte
  task automatic urx(output logic [15:0] w);
    int b;
    int j;
    int k;
    w = 16'h0000;
    for (b = 0; b < 2; b++)
    begin
      k = 0;
      while (uart_tx !== 1'b0 && k < 4000)
      begin
        tick(1);
        k++;
      end
      if (k == 4000)
      begin
        n_mismatch++;
        print_verdict();
      end
      tick(bt / 2);
      for (j = 0; j < 8; j++)
      begin
        tick(bt);
        w[8*(1-b)+j] = uart_tx;
      end
      tick(bt);
      cmp16({15'h0000, uart_tx}, 16'h0001);
    end
  endtask

  // Arm, stream samples, then upload and compare the record
  task automatic capture(input logic [15:0] len, input int nsend, input int nexp);
    logic [15:0] w;
    int          i;
    sent = {};
    wr(`REG_REC_LEN, len);
    wr(`REG_CTRL, 16'h0001);
    cmp_st(cap_state, CAP_RUN);
    for (i = 0; i < nsend; i++)
    begin
      w = $urandom;
      sent.push_back(w);
      adc.send(1'b1, 1'b1, 16, w);
    end
    tick(8);
    cmp_st(cap_state, CAP_FULL);
    fork
      wr(`REG_CTRL, 16'h0002);
      for (i = 0; i < nexp; i++)
      begin
        urx(w);
        cmp16(w, sent[i]);
      end
    join
    tick(20);
    cmp_st(cap_state, CAP_FULL);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    int          mi;
    int          k;
    int          res;
    logic [15:0] w;
    logic        hc;
    void'($urandom(22094));
    {rst, cfg_serial, cfg_fmt, cfg_res, clr_req, uart_rx} = 7'b1_0000_01;
    n_mismatch = 0;
    checks = 0;
    bt = 868;
    // Straps are latched once, so every format needs its own reset
    for (mi = 0; mi < 7; mi++)
    begin
      {cfg_serial, cfg_fmt, cfg_res} = modes[mi];
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(6);
      res = (cfg_res == 2'b00) ? 12 : (cfg_res == 2'b01) ? 14 : 16;
      cmp16({15'h0000, hdr_oe}, {15'h0000, cfg_serial});
      for (k = 0; k < 4; k++)
      begin
        w = (k == 0) ? 16'hAAAA : $urandom;
        hc = hdr_clk;
        adc.send(cfg_serial, cfg_fmt, res, w);
        tick(6);
        cmp16(hdr_data, exp_word(cfg_serial, cfg_fmt, res, w));
        cmp16({15'h0000, hdr_clk}, {15'h0000, ~hc});
      end
    end
    // Divisor below the floor is forced up to 4, five cycles a bit
    wr(`REG_BAUD, 16'h0001);
    bt = 5;
    // Channel 3 is pair 6/7; 0xFF clamps to 13, which selects pair 10/11
    for (k = 0; k < 2; k++)
    begin
      wr(`REG_CHAN, (k == 0) ? 16'h0003 : 16'h00FF);
      adc.ch = (k == 0) ? 3 : 5;
      w = $urandom;
      adc.send(1'b1, 1'b1, 16, w);
      tick(6);
      cmp16(hdr_data, w);
    end
    // Serial straps turn the header on; the host may turn it off again
    wr(`REG_HDR_EN, 16'h0000);
    cmp16({15'h0000, hdr_oe}, 16'h0000);
    wr(`REG_CTRL, 16'h0002);
    tick(20);
    cmp_st(cap_state, CAP_IDLE);
    cmp16({15'h0000, uart_tx}, 16'h0001);
    capture(16'h0003, 6, 4);
    clr_req = 1'b1;
    tick(4);
    clr_req = 1'b0;
    tick(4);
    // Baud must survive the clear, or this upload fails
    capture(16'h1234, DEPTH + 2, DEPTH);
    print_verdict();
  end

  // Watchdog against a hang anywhere
  initial
  begin
    #900000;
    n_mismatch++;
    print_verdict();
  end
endmodule
